// ===== hw/ssr_pkg.sv
// Package with the bit layout, reset values and codes of the status reporting block.
package ssr_pkg;
    localparam int unsigned SSR_BYTE_W      = 8;
    localparam int unsigned SSR_PROT_W      = 17;
    localparam int unsigned SSR_RSP_W       = 32;

    // Standard event latch bit positions.
    localparam int unsigned SSR_EV_OPC      = 0;
    localparam int unsigned SSR_EV_REQCTL   = 1;
    localparam int unsigned SSR_EV_QUERY    = 2;
    localparam int unsigned SSR_EV_DEVDEP   = 3;
    localparam int unsigned SSR_EV_EXEC     = 4;
    localparam int unsigned SSR_EV_CMD      = 5;
    localparam int unsigned SSR_EV_USER     = 6;
    localparam int unsigned SSR_EV_PON      = 7;

    // Status byte bit positions.
    localparam int unsigned SSR_SB_UNUSED0  = 0;
    localparam int unsigned SSR_SB_PROT     = 1;
    localparam int unsigned SSR_SB_ERRQ     = 2;
    localparam int unsigned SSR_SB_QUES     = 3;
    localparam int unsigned SSR_SB_MSG      = 4;
    localparam int unsigned SSR_SB_EVSUM    = 5;
    localparam int unsigned SSR_SB_REQ      = 6;
    localparam int unsigned SSR_SB_OPER     = 7;

    // Event bits that internal conditions may set; request control and user request never.
    localparam logic [7:0]  SSR_EV_USED     = 8'hBD;
    // Service condition ignores the request-service bit itself.
    localparam logic [7:0]  SSR_SB_SRV_MASK = 8'hBF;

    localparam logic [7:0]  SSR_RST_BYTE    = 8'h00;
    localparam logic [16:0] SSR_RST_PROT    = 17'h00000;
    localparam logic [31:0] SSR_RST_RSP     = 32'h00000000;

    // Which query the response word answers.
    typedef enum logic [2:0] {
        SSR_SRC_EVL  = 3'h0,
        SSR_SRC_EVM  = 3'h1,
        SSR_SRC_SVM  = 3'h2,
        SSR_SRC_BYT  = 3'h3,
        SSR_SRC_POLL = 3'h4,
        SSR_SRC_PEV  = 3'h5,
        SSR_SRC_PEN  = 3'h6
    } ssr_src_e;
endpackage : ssr_pkg

// ===== hw/ssr_event_latch.sv
// Sticky event latch with a per-bit admit mask and a clear that loses to a new event.
`timescale 1ns/1ps
`default_nettype none
module ssr_event_latch #(
    parameter int unsigned W = 8
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] set_in,
    input  wire logic [W-1:0] admit,
    input  wire logic         clear,
    output var  logic [W-1:0] latch_q
);
    logic [W-1:0] latch_d;

    // An event in the clearing cycle survives so that it is never lost.
    always_comb begin
        latch_d = (clear ? '0 : latch_q) | (set_in & admit);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            latch_q <= '0;
        end else begin
            latch_q <= latch_d;
        end
    end
endmodule : ssr_event_latch
`default_nettype wire

// ===== hw/ssr_mask_reg.sv
// Plain write-and-hold mask register.
`timescale 1ns/1ps
`default_nettype none
module ssr_mask_reg #(
    parameter int unsigned W = 8
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         wr,
    input  wire logic [W-1:0] wr_data,
    output var  logic [W-1:0] mask_q
);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mask_q <= '0;
        end else if (wr) begin
            mask_q <= wr_data;
        end
    end
endmodule : ssr_mask_reg
`default_nettype wire

// ===== hw/ssr_top.sv
// Status byte, standard event latch and service request logic of the instrument.
`timescale 1ns/1ps
`default_nettype none
module ssr_top (
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    input  wire logic                          gpib_active,
    input  wire logic [ssr_pkg::SSR_BYTE_W-1:0] event_pulse,
    input  wire logic [ssr_pkg::SSR_PROT_W-1:0] prot_event,
    input  wire logic                          err_queue_nonempty,
    input  wire logic                          message_waiting,
    input  wire logic                          clear_status_command,
    input  wire logic                          standard_event_latch_query,
    input  wire logic                          event_enable_mask_command,
    input  wire logic                          event_enable_mask_query,
    input  wire logic                          service_request_mask_command,
    input  wire logic                          service_request_mask_query,
    input  wire logic                          summary_status_byte_query,
    input  wire logic                          serial_poll,
    input  wire logic                          prot_enable_command,
    input  wire logic                          prot_enable_query,
    input  wire logic                          prot_event_query,
    input  wire logic [ssr_pkg::SSR_RSP_W-1:0]  cmd_data,
    output var  logic                          rsp_valid_q,
    output var  logic [ssr_pkg::SSR_RSP_W-1:0]  rsp_data_q,
    output var  logic                          request_service_flag_q,
    output var  logic                          srq_q
);
    import ssr_pkg::*;

    logic [SSR_BYTE_W-1:0] standard_event_latch;
    logic [SSR_BYTE_W-1:0] event_enable_mask;
    logic [SSR_BYTE_W-1:0] service_request_mask;
    logic [SSR_PROT_W-1:0] prot_enable_mask;
    logic [SSR_PROT_W-1:0] prot_latch;
    logic [SSR_BYTE_W-1:0] status_base;
    logic                  message_waiting_flag;
    logic                  srv_cond;
    logic                  srv_cond_q;
    logic                  poll_ok;
    logic                  evl_clear;
    logic                  prot_clear;
    logic                  request_service_flag_d;
    logic                  rsp_valid_d;
    logic [SSR_RSP_W-1:0]  rsp_data_d;
    logic [SSR_BYTE_W-1:0] ev_mask_copy_q;
    logic [SSR_BYTE_W-1:0] sv_mask_copy_q;

    // Zero-extend a byte to the response width.
    function automatic logic [SSR_RSP_W-1:0] ssr_widen(input logic [SSR_BYTE_W-1:0] b);
        ssr_widen = {{(SSR_RSP_W - SSR_BYTE_W){1'b0}}, b};
    endfunction : ssr_widen

    // Replace bit 6 of the status byte with the given indication.
    function automatic logic [SSR_BYTE_W-1:0] ssr_with_b6(input logic [SSR_BYTE_W-1:0] b, input logic v);
        logic [SSR_BYTE_W-1:0] r;
        r = b;
        r[SSR_SB_REQ] = v;
        ssr_with_b6 = r;
    endfunction : ssr_with_b6

    assign evl_clear  = standard_event_latch_query | clear_status_command;
    assign prot_clear = prot_event_query | clear_status_command;
    // Serial poll only exists on the GPIB link; elsewhere the strobe is ignored.
    assign poll_ok    = serial_poll & gpib_active;

    ssr_event_latch #(
        .W       (SSR_BYTE_W)
    ) u_event_latch (
        .ref_clk (ref_clk),
        .rst     (rst),
        .set_in  (event_pulse),
        .admit   (SSR_EV_USED),
        .clear   (evl_clear),
        .latch_q (standard_event_latch)
    );

    ssr_event_latch #(
        .W       (SSR_PROT_W)
    ) u_prot_latch (
        .ref_clk (ref_clk),
        .rst     (rst),
        .set_in  (prot_event),
        .admit   (prot_enable_mask),
        .clear   (prot_clear),
        .latch_q (prot_latch)
    );

    ssr_mask_reg #(
        .W       (SSR_BYTE_W)
    ) u_event_mask (
        .ref_clk (ref_clk),
        .rst     (rst),
        .wr      (event_enable_mask_command),
        .wr_data (cmd_data[SSR_BYTE_W-1:0]),
        .mask_q  (event_enable_mask)
    );

    ssr_mask_reg #(
        .W       (SSR_BYTE_W)
    ) u_service_mask (
        .ref_clk (ref_clk),
        .rst     (rst),
        .wr      (service_request_mask_command),
        .wr_data (cmd_data[SSR_BYTE_W-1:0]),
        .mask_q  (service_request_mask)
    );

    ssr_mask_reg #(
        .W       (SSR_PROT_W)
    ) u_prot_mask (
        .ref_clk (ref_clk),
        .rst     (rst),
        .wr      (prot_enable_command),
        .wr_data (cmd_data[SSR_PROT_W-1:0]),
        .mask_q  (prot_enable_mask)
    );

    assign message_waiting_flag = message_waiting & gpib_active;

    // Status byte without bit 6; clearing the latches clears bits 1 and 5, while bit 2 follows the error queue and bit 4 the message input gated by GPIB.
    always_comb begin
        status_base                 = SSR_RST_BYTE;
        status_base[SSR_SB_PROT]    = |prot_latch;
        status_base[SSR_SB_ERRQ]    = err_queue_nonempty;
        status_base[SSR_SB_MSG]     = message_waiting_flag;
        status_base[SSR_SB_EVSUM]   = |(standard_event_latch & event_enable_mask);
    end

    assign srv_cond = |(status_base & service_request_mask & SSR_SB_SRV_MASK);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            srv_cond_q <= 1'b0;
        end else begin
            srv_cond_q <= srv_cond;
        end
    end

    // A new reason sets the flag even in the cycle of a poll or clear, so it is not lost.
    always_comb begin
        request_service_flag_d = request_service_flag_q;
        if (poll_ok || clear_status_command) begin
            request_service_flag_d = 1'b0;
        end
        if (srv_cond && !srv_cond_q) begin
            request_service_flag_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            request_service_flag_q <= 1'b0;
        end else begin
            request_service_flag_q <= request_service_flag_d;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            srq_q <= 1'b0;
        end else begin
            srq_q <= request_service_flag_d & gpib_active;
        end
    end

    // One answer per cycle; of simultaneous queries only the first in this fixed order is answered.
    always_comb begin
        rsp_valid_d = 1'b1;
        rsp_data_d  = rsp_data_q;
        if (standard_event_latch_query) begin
            rsp_data_d = ssr_widen(standard_event_latch);
        end else if (event_enable_mask_query) begin
            rsp_data_d = ssr_widen(event_enable_mask);
        end else if (service_request_mask_query) begin
            rsp_data_d = ssr_widen(service_request_mask);
        end else if (summary_status_byte_query) begin
            rsp_data_d = ssr_widen(ssr_with_b6(status_base, srv_cond));
        end else if (poll_ok) begin
            rsp_data_d = ssr_widen(ssr_with_b6(status_base, request_service_flag_q));
        end else if (prot_event_query) begin
            rsp_data_d = {{(SSR_RSP_W - SSR_PROT_W){1'b0}}, prot_latch};
        end else if (prot_enable_query) begin
            rsp_data_d = {{(SSR_RSP_W - SSR_PROT_W){1'b0}}, prot_enable_mask};
        end else begin
            rsp_valid_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q  <= SSR_RST_RSP;
        end else begin
            rsp_valid_q <= rsp_valid_d;
            rsp_data_q  <= rsp_data_d;
        end
    end

    // Independent copies of the event and service request masks; the readback checks compare against these, not the mask registers.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ev_mask_copy_q <= SSR_RST_BYTE;
        end else if (event_enable_mask_command) begin
            ev_mask_copy_q <= cmd_data[SSR_BYTE_W-1:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sv_mask_copy_q <= SSR_RST_BYTE;
        end else if (service_request_mask_command) begin
            sv_mask_copy_q <= cmd_data[SSR_BYTE_W-1:0];
        end
    end

    property p_evl_read_clears;
        @(posedge ref_clk) disable iff (rst)
        (standard_event_latch_query && !(|event_pulse)) |=> (standard_event_latch == 8'h00);
    endproperty
    a_evl_read_clears: assert property (p_evl_read_clears) else $error("event latch not cleared by read");

    property p_evl_read_data;
        @(posedge ref_clk) disable iff (rst)
        standard_event_latch_query |=> (rsp_valid_q && rsp_data_q[7:0] == $past(standard_event_latch));
    endproperty
    a_evl_read_data: assert property (p_evl_read_data) else $error("event latch query returned wrong value");

    property p_unused_events;
        @(posedge ref_clk) disable iff (rst)
        ((standard_event_latch & 8'h42) == 8'h00);
    endproperty
    a_unused_events: assert property (p_unused_events) else $error("unused event bit set");

    property p_event_latch_sets;
        @(posedge ref_clk) disable iff (rst)
        event_pulse[SSR_EV_EXEC] |=> standard_event_latch[SSR_EV_EXEC];
    endproperty
    a_event_latch_sets: assert property (p_event_latch_sets) else $error("execution event not latched");

    property p_evmask_readback;
        @(posedge ref_clk) disable iff (rst)
        (event_enable_mask_query && !standard_event_latch_query)
            |=> (rsp_valid_q && rsp_data_q[7:0] == $past(ev_mask_copy_q));
    endproperty
    a_evmask_readback: assert property (p_evmask_readback) else $error("event mask readback differs");

    property p_svmask_readback;
        @(posedge ref_clk) disable iff (rst)
        (service_request_mask_query && !standard_event_latch_query && !event_enable_mask_query)
            |=> (rsp_valid_q && rsp_data_q[7:0] == $past(sv_mask_copy_q));
    endproperty
    a_svmask_readback: assert property (p_svmask_readback) else $error("service mask readback differs");

    property p_byte_query_bit6;
        @(posedge ref_clk) disable iff (rst)
        (summary_status_byte_query && !standard_event_latch_query && !event_enable_mask_query
            && !service_request_mask_query) |=> (rsp_data_q[6] == $past(srv_cond) && rsp_data_q[5] == $past(
            |(standard_event_latch & event_enable_mask)));
    endproperty
    a_byte_query_bit6: assert property (p_byte_query_bit6) else $error("status query bit 6 or 5 wrong");

    property p_poll_clears_flag;
        @(posedge ref_clk) disable iff (rst)
        (poll_ok && !(srv_cond && !srv_cond_q)) |=> !request_service_flag_q;
    endproperty
    a_poll_clears_flag: assert property (p_poll_clears_flag) else $error("request flag kept after poll");

    property p_flag_rises;
        @(posedge ref_clk) disable iff (rst)
        (srv_cond && !srv_cond_q) |=> (request_service_flag_q && (srq_q == $past(gpib_active)));
    endproperty
    a_flag_rises: assert property (p_flag_rises) else $error("service request not raised");

    property p_unused_byte_bits;
        @(posedge ref_clk) disable iff (rst)
        (rsp_valid_q && $past(summary_status_byte_query || poll_ok) && !$past(standard_event_latch_query
            || event_enable_mask_query || service_request_mask_query)) |-> ((rsp_data_q & 32'h00000089) == 32'h0);
    endproperty
    a_unused_byte_bits: assert property (p_unused_byte_bits) else $error("unused status byte bit set");

    property p_cls_clears;
        @(posedge ref_clk) disable iff (rst)
        (clear_status_command && !(|event_pulse) && !(|prot_event) && !(srv_cond && !srv_cond_q))
            |=> (standard_event_latch == 8'h00 && prot_latch == 17'h0 && !request_service_flag_q);
    endproperty
    a_cls_clears: assert property (p_cls_clears) else $error("clear-status left state behind");

    property p_prot_gated;
        @(posedge ref_clk) disable iff (rst)
        $rose(|prot_latch) |-> |($past(prot_event) & $past(prot_enable_mask));
    endproperty
    a_prot_gated: assert property (p_prot_gated) else $error("protection bit latched while disabled");

    property p_msg_gpib;
        @(posedge ref_clk) disable iff (rst)
        !gpib_active |-> !status_base[SSR_SB_MSG];
    endproperty
    a_msg_gpib: assert property (p_msg_gpib) else $error("message flag off GPIB");

    property p_line_off_link;
        @(posedge ref_clk) disable iff (rst)
        !$past(gpib_active) |-> !srq_q;
    endproperty
    a_line_off_link: assert property (p_line_off_link) else $error("service request line driven off GPIB");
endmodule : ssr_top
`default_nettype wire

// ===== verification/ssr_ctrl_model.sv
// Behavioural remote controller that issues one command or query at a time.
`timescale 1ns/1ps
`default_nettype none
module ssr_ctrl_model (
    input  wire logic        ref_clk,
    input  wire logic        gpib_active,
    input  wire logic        rsp_valid_q,
    input  wire logic [31:0] rsp_data_q,
    output var  logic [10:0] strobe,
    output var  logic [31:0] cmd_data
);
    localparam int POLL_IDX = 6;
    // Set only by a scenario that means to poll over a non-GPIB link.
    logic rogue;

    initial begin
        strobe   = 11'h000;
        cmd_data = 32'h00000000;
        rogue    = 1'b0;
    end

    task automatic xfer(input int idx, input logic [31:0] d, output logic vld, output logic [31:0] r);
        vld = 1'b0;
        r   = 32'h00000000;
        if (idx != POLL_IDX || gpib_active || rogue) begin
            @(posedge ref_clk);
            strobe[idx] <= 1'b1;
            cmd_data    <= d;
            @(posedge ref_clk);
            strobe[idx] <= 1'b0;
            // Released data shows the inverse so a stale value is never mistaken for a live one.
            cmd_data    <= ~d;
            @(posedge ref_clk);
            vld = rsp_valid_q;
            r   = rsp_data_q;
        end
    endtask : xfer
endmodule : ssr_ctrl_model
`default_nettype wire

// ===== verification/status_byte_service_request_tb.sv
// Self-checking bench of the status byte and service request logic.
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("ERROR %s expected %0h seen %0h", what, exp, got); end end
module status_byte_service_request_tb;
    import ssr_pkg::*;
    localparam int Q_EVL = 0, W_EVM = 1, Q_EVM = 2, W_SVM = 3, Q_SVM = 4, Q_BYTE = 5;
    localparam int POLL = 6, W_PEN = 7, Q_PEN = 8, Q_PEV = 9, CLR = 10;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        gpib_active = 1'b0;
    logic        errq = 1'b0;
    logic        msg = 1'b0;
    logic [7:0]  ev = 8'h00;
    logic [16:0] pe = 17'h00000;
    logic [10:0] strobe;
    logic [31:0] cmd_data, rsp_data_q, a, b, c;
    logic        rsp_valid_q, request_service_flag_q, srq_q;
    logic [7:0]  evl_m = 8'h00, evm_m = 8'h00, svm_m = 8'h00, lv;
    logic [16:0] pen_m = 17'h00000, pev_m = 17'h00000;
    logic        flag_m = 1'b0, cond_p = 1'b0;
    int          qlist[6] = '{Q_EVL, Q_EVM, Q_SVM, Q_BYTE, Q_PEN, Q_PEV};
    int          bad_count = 0;
    int          total_checks = 0;

    always #12.5 ref_clk = ~ref_clk;

    ssr_top i_ssr_top (.ref_clk, .rst, .gpib_active, .event_pulse(ev), .prot_event(pe),
        .err_queue_nonempty(errq), .message_waiting(msg), .clear_status_command(strobe[CLR]),
        .standard_event_latch_query(strobe[Q_EVL]), .event_enable_mask_command(strobe[W_EVM]),
        .event_enable_mask_query(strobe[Q_EVM]), .service_request_mask_command(strobe[W_SVM]),
        .service_request_mask_query(strobe[Q_SVM]), .summary_status_byte_query(strobe[Q_BYTE]),
        .serial_poll(strobe[POLL]), .prot_enable_command(strobe[W_PEN]),
        .prot_enable_query(strobe[Q_PEN]), .prot_event_query(strobe[Q_PEV]), .cmd_data,
        .rsp_valid_q, .rsp_data_q, .request_service_flag_q, .srq_q);

    ssr_ctrl_model i_ssr_ctrl_model (.ref_clk, .gpib_active, .rsp_valid_q, .rsp_data_q, .strobe, .cmd_data);

    function automatic logic [7:0] sbyte(input logic six);
        return {1'b0, six, |(evl_m & evm_m), msg & gpib_active, 1'b0, errq, |pev_m, 1'b0};
    endfunction : sbyte

    // The flag is raised only on a rising service condition, so the model tracks the last value.
    task automatic upd();
        logic cnd;
        cnd = |(sbyte(1'b0) & svm_m & 8'hBF);
        if (cnd && !cond_p) flag_m = 1'b1;
        cond_p = cnd;
    endtask : upd

    task automatic op(input int idx, input logic [31:0] d, input logic [31:0] e, input string nm);
        logic        v;
        logic [31:0] r;
        i_ssr_ctrl_model.xfer(idx, d, v, r);
        `CHK({nm, "_valid"}, (nm != ""), v)
        if (nm != "") `CHK(nm, e, r)
        case (idx)
            Q_EVL: evl_m = 8'h00;
            Q_PEV: pev_m = 17'h00000;
            W_EVM: evm_m = d[7:0];
            W_SVM: svm_m = d[7:0];
            W_PEN: pen_m = d[16:0];
            POLL: if (gpib_active) flag_m = 1'b0;
            CLR: begin
                evl_m = 8'h00;
                pev_m = 17'h00000;
                flag_m = 1'b0;
            end
            default: ;
        endcase
        upd();
    endtask : op

    task automatic fire(input logic [7:0] e, input logic [16:0] p);
        @(posedge ref_clk);
        ev <= e;
        pe <= p;
        @(posedge ref_clk);
        ev <= 8'h00;
        pe <= 17'h00000;
        evl_m |= e & SSR_EV_USED;
        pev_m |= p & pen_m;
        upd();
    endtask : fire

    task automatic setlv(input logic [2:0] l);
        @(posedge ref_clk);
        gpib_active <= l[0];
        errq        <= l[1];
        msg         <= l[2];
        #1;
        upd();
    endtask : setlv

    task automatic chk_flag();
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK("flag", flag_m, request_service_flag_q)
        `CHK("srq", flag_m & gpib_active, srq_q)
    endtask : chk_flag

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        report_and_stop();
    end

    initial begin
        void'($urandom(32'h7C26A1AF));
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (qlist[i]) op(qlist[i], 0, 0, "reset_value");
        op(Q_PEV, 0, 0, "reset_pev");
        setlv(3'b001);
        op(W_PEN, 32'h0001FFFF, 0, "");
        op(W_SVM, 32'h00000002, 0, "");
        fire(8'h00, 17'h00008);
        op(Q_BYTE, 0, 32'h42, "byte_prot");
        chk_flag();
        op(POLL, 0, 32'h42, "poll_prot");
        chk_flag();
        op(Q_BYTE, 0, 32'h42, "byte_after_poll");
        op(Q_PEV, 0, 32'h8, "pev_read");
        op(W_EVM, 32'h20, 0, "");
        op(W_SVM, 32'h20, 0, "");
        fire(8'h20, 17'h00000);
        chk_flag();
        setlv(3'b000);
        i_ssr_ctrl_model.rogue = 1'b1;
        op(POLL, 0, 0, "");
        chk_flag();
        i_ssr_ctrl_model.rogue = 1'b0;
        repeat (40) begin
            a  = $urandom;
            b  = $urandom;
            c  = $urandom;
            lv = 8'($urandom);
            op(W_EVM, a, 0, "");
            op(Q_EVM, 0, {24'h0, evm_m}, "ev_mask");
            op(W_SVM, b, 0, "");
            op(Q_SVM, 0, {24'h0, svm_m}, "sv_mask");
            op(W_PEN, c, 0, "");
            op(Q_PEN, 0, {15'h0, pen_m}, "pen");
            setlv(lv[2:0]);
            fire(a[15:8], b[24:8]);
            chk_flag();
            op(Q_BYTE, 0, {24'h0, sbyte(cond_p)}, "byte");
            if (lv[3]) op(POLL, 0, {24'h0, sbyte(flag_m)}, gpib_active ? "poll" : "");
            if (lv[4]) op(CLR, 0, 0, "");
            op(Q_EVL, 0, {24'h0, evl_m}, "ev_latch");
            op(Q_BYTE, 0, {24'h0, sbyte(cond_p)}, "byte_after_read");
            op(Q_PEV, 0, {15'h0, pev_m}, "pev");
            chk_flag();
        end
        report_and_stop();
    end
endmodule : status_byte_service_request_tb
`default_nettype wire
